// ### tb/light_threshold_limit_regs_tb.sv
// Purpose: self-checking bench for the threshold register block
// Assumes: host model drives the bus, bench drives measurements
// Notes:   bench inputs change on falling clock edges
module light_threshold_limit_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk, arst_n, scl, sda, sda_out, sda_oe_n, valid, mask;
  ltl_pkg::ltl_float_t result, lower, result_value;
  ltl_pkg::ltl_flags_t flags;
  logic [15:0]         upper;
  int                  n_fail, checks;
  always #5 clk = ~clk;
  ltl_threshold_regs u_ltl_threshold_regs (.i_clk(clk), .i_arst_n(arst_n), .i_scl(scl),
    .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_result(result),
    .i_result_valid(valid), .i_lower_limit(lower), .i_comparison_mask_enable(mask),
    .o_result_value(result_value), .o_flags(flags));
  ltl_host_model u_ltl_host_model (.i_clk(clk), .i_sda_out(sda_out),
    .i_sda_oe_n(sda_oe_n), .o_scl(scl), .o_sda(sda));
  // ****************
  // helpers
  // ****************
  function automatic logic [26:0] lx(logic [15:0] v, logic m);
    return 27'(v[11:0]) << (m ? 4'h0 : v[15:12]);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic [15:0] x;
    u_ltl_host_model.access(p, 1'b1, d, x);
  endtask
  task automatic rchk(input logic [7:0] p, input logic [15:0] e);
    logic [15:0] d;
    u_ltl_host_model.access(p, 1'b0, 16'h0000, d);
    chk(d, e);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic test_reset();
    rchk(ltl_pkg::REG_UPPER_LUX_THRESHOLD, 16'hBFFF);
    rchk(ltl_pkg::REG_MAKER_IDENTIFICATION, ltl_pkg::MAKER_CODE_VALUE);
    $display("test reset done");
  endtask
  task automatic test_regs();
    wr(ltl_pkg::REG_UPPER_LUX_THRESHOLD, 16'h1234);
    rchk(ltl_pkg::REG_UPPER_LUX_THRESHOLD, 16'h1234);
    wr(ltl_pkg::REG_UPPER_LUX_THRESHOLD, 16'hA5C3);
    rchk(ltl_pkg::REG_UPPER_LUX_THRESHOLD, 16'hA5C3);
    wr(ltl_pkg::REG_MAKER_IDENTIFICATION, 16'hFFFF);
    rchk(ltl_pkg::REG_MAKER_IDENTIFICATION, ltl_pkg::MAKER_CODE_VALUE);
    wr(8'h10, 16'h0F0F);
    rchk(8'h10, 16'h0000);
    rchk(ltl_pkg::REG_UPPER_LUX_THRESHOLD, 16'hA5C3);
    chk({15'h0000, u_ltl_host_model.ack_bad}, 16'h0000);
    // a foreign address must go unanswered
    u_ltl_host_model.start();
    u_ltl_host_model.put({~ltl_pkg::BUS_DEVICE_ADDRESS, 1'b0});
    u_ltl_host_model.stop();
    chk({15'h0000, u_ltl_host_model.ack_bad}, 16'h0001);
    rchk(ltl_pkg::REG_UPPER_LUX_THRESHOLD, 16'hA5C3);
    $display("test regs done");
  endtask
  task automatic test_flags();
    logic [15:0] res [8] = '{16'h0401, 16'h0400, 16'h01FF, 16'h5000,
                             16'hFFFF, 16'h2101, 16'h0150, 16'h2070};
    logic [7:0]  msk = 8'hE0;
    upper = 16'h2100;
    wr(ltl_pkg::REG_UPPER_LUX_THRESHOLD, upper);
    for (int i = 0; i < 8; i++) begin
      lower = 16'h2080;
      result = res[i];
      mask = msk[i];
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      @(negedge clk);
      chk(result_value, res[i]);
      chk({14'h0000, flags}, {14'h0000, lx(res[i], mask) > lx(upper, mask),
          lx(res[i], mask) < lx(lower, mask)});
    end
    $display("test flags done");
  endtask
  task automatic test_mid_reset();
    @(negedge clk);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(result_value, 16'h0000);
    chk({14'h0000, flags}, 16'h0000);
    arst_n = 1'b1;
    @(negedge clk);
    rchk(ltl_pkg::REG_UPPER_LUX_THRESHOLD, ltl_pkg::UPPER_LUX_THRESHOLD_RESET);
    $display("test mid reset done");
  endtask
  task automatic finish_test();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0; arst_n = 1'b0; valid = 1'b0; mask = 1'b0;
    result = 16'h0000; lower = 16'h0000; n_fail = 0; checks = 0;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    test_reset();
    test_regs();
    test_flags();
    test_mid_reset();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule

// ### tb/ltl_host_model.sv
// Purpose: two-wire bus host that reaches the block registers
// Assumes: bus lines change on falling clock edges
// Notes:   sda resolves as a pulled-up open-drain wire
module ltl_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda_out,
  input  wire logic i_sda_oe_n,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_sda = 1'b1;
  logic ack_bad  = 1'b0;
  initial o_scl = 1'b1;
  assign o_sda = host_sda & (i_sda_oe_n | i_sda_out);
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    wt(1); host_sda = b; wt(3); o_scl = 1'b1; wt(2); r = o_sda; wt(2); o_scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
                         output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask
  task automatic put(input logic [7:0] d);
    logic [7:0] q;
    logic       k;
    byte_io(d, 1'b1, q, k);
    ack_bad |= k;
  endtask
  // also serves as repeated start while scl is low
  task automatic start();
    wt(1); host_sda = 1'b1; wt(3); o_scl = 1'b1; wt(4); host_sda = 1'b0; wt(4); o_scl = 1'b0;
  endtask
  task automatic stop();
    wt(1); host_sda = 1'b0; wt(3); o_scl = 1'b1; wt(4); host_sda = 1'b1; wt(4);
  endtask
  task automatic access(input logic [7:0] p, input logic w, input logic [15:0] wd,
                        output logic [15:0] rd);
    logic k;
    rd = 16'h0000;
    start(); put({ltl_pkg::BUS_DEVICE_ADDRESS, 1'b0}); put(p);
    if (w) begin
      put(wd[15:8]); put(wd[7:0]);
    end else begin
      start(); put({ltl_pkg::BUS_DEVICE_ADDRESS, 1'b1});
      byte_io(8'hFF, 1'b0, rd[15:8], k); byte_io(8'hFF, 1'b1, rd[7:0], k);
    end
    stop();
  endtask
endmodule

// ### tb/ltl_threshold_regs_monitor.sv
// Purpose: port assertions for the threshold register block
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every instance of ltl_threshold_regs
module ltl_threshold_regs_monitor (
  input wire logic                i_clk,
  input wire logic                i_arst_n,
  input wire logic                i_scl,
  input wire logic                i_sda,
  input wire logic                o_sda_out,
  input wire logic                o_sda_oe_n,
  input wire ltl_pkg::ltl_float_t i_result,
  input wire logic                i_result_valid,
  input wire ltl_pkg::ltl_float_t i_lower_limit,
  input wire logic                i_comparison_mask_enable,
  input wire ltl_pkg::ltl_float_t o_result_value,
  input wire ltl_pkg::ltl_flags_t o_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ****************
  // lux scaling
  // ****************
  function automatic logic [26:0] lx(ltl_pkg::ltl_float_t v);
    return 27'(v.mantissa) << v.exponent;
  endfunction
  a_result_capture: assert property (i_result_valid |=> o_result_value == $past(i_result))
    else $error("result not captured");
  a_result_hold: assert property (!i_result_valid |=> $stable(o_result_value))
    else $error("result changed without a measurement");
  a_flags_hold: assert property (!i_result_valid |=> $stable(o_flags))
    else $error("flags changed without a measurement");
  a_under_lux: assert property (i_result_valid && !i_comparison_mask_enable |=>
    o_flags.under_threshold_flag == (lx($past(i_result)) < lx($past(i_lower_limit))))
    else $error("under flag wrong in lux compare");
  a_under_masked: assert property (i_result_valid && i_comparison_mask_enable |=>
    o_flags.under_threshold_flag == ($past(i_result.mantissa) < $past(i_lower_limit.mantissa)))
    else $error("under flag wrong in masked compare");
  a_over_zero: assert property (i_result_valid && i_result.mantissa == 12'h000 |=>
    !o_flags.over_threshold_flag) else $error("over flag on zero result");
  a_under_full: assert property (i_result_valid && i_result == 16'hFFFF |=>
    !o_flags.under_threshold_flag) else $error("under flag on full scale");
  a_ack_scl_low: assert property ($fell(o_sda_oe_n) |-> !i_scl)
    else $error("data pulled low while clock high");
  cover property (i_result_valid && i_comparison_mask_enable);
  cover property (o_flags.over_threshold_flag);
  cover property ($fell(o_sda_oe_n));
endmodule

bind ltl_threshold_regs ltl_threshold_regs_monitor u_ltl_threshold_regs_monitor (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .i_result(i_result),
  .i_result_valid(i_result_valid), .i_lower_limit(i_lower_limit),
  .i_comparison_mask_enable(i_comparison_mask_enable),
  .o_result_value(o_result_value), .o_flags(o_flags));

// ### verilog/ltl_lux_scale.sv
// Purpose: turn an exponent and mantissa word into a linear lux count
// Assumes: one count is 0.01 lux at exponent zero
// Notes:   purely combinational; widest result is 12 + 15 bits
module ltl_lux_scale (
  input  wire ltl_pkg::ltl_float_t        i_value,
  output logic [ltl_pkg::LUX_W-1:0]       o_lux
);

  // ****************************************
  // scaling
  // ****************************************
  // step doubles and full scale doubles with each exponent increment
  always_comb begin
    o_lux = ltl_pkg::LUX_W'({15'h0000, i_value.mantissa}) << i_value.exponent;
  end

endmodule

// ### verilog/ltl_pkg.sv
// Purpose: shared constants and types for the light threshold block
// Assumes: 16-bit registers reached over a two-wire serial bus
// Notes:   limit and result words hold a 4-bit exponent and 12-bit mantissa
package ltl_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  REG_UPPER_LUX_THRESHOLD   = 8'h03;
  localparam logic [7:0]  REG_MAKER_IDENTIFICATION  = 8'h7E;
  localparam logic [15:0] UPPER_LUX_THRESHOLD_RESET = 16'hBFFF;
  localparam logic [15:0] UNMAPPED_READ_VALUE       = 16'h0000;
  // arbitrary neutral maker code
  localparam logic [15:0] MAKER_CODE_VALUE          = 16'h1A2B;

  // ****************************************
  // field layout
  // ****************************************
  localparam int EXPONENT_MSB = 15;
  localparam int EXPONENT_LSB = 12;
  localparam int MANTISSA_MSB = 11;
  localparam int MANTISSA_LSB = 0;
  localparam logic [3:0]  UPPER_EXPONENT_RESET = 4'hB;
  localparam logic [11:0] UPPER_MANTISSA_RESET = 12'hFFF;

  // lux in steps of 0.01 lux: mantissa shifted left by the exponent
  localparam int LUX_STEP_CENTILUX = 1;
  localparam int LUX_W             = 27;

  // ****************************************
  // serial bus
  // ****************************************
  localparam logic [6:0] BUS_DEVICE_ADDRESS = 7'h44;
  localparam logic [3:0] BITS_PER_BYTE      = 4'h8;

  typedef struct packed {
    logic [3:0]  exponent;
    logic [11:0] mantissa;
  } ltl_float_t;

  typedef struct packed {
    logic over_threshold_flag;
    logic under_threshold_flag;
  } ltl_flags_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } ltl_state_t;

endpackage

// ### verilog/ltl_threshold_regs.sv
// Purpose: upper threshold and maker code registers with lux comparison
// Assumes: scl and sda inputs are synchronous to i_clk
// Notes:   sda is open drain; o_sda_oe_n low pulls the wire low
//
// Operation
// - with the mask enable low, result and both limits are scaled to lux before comparing, each with its own exponent.
// - the upper threshold is the upper bound that drives the over flag; i_lower_limit drives the under flag.
// - the 16-bit read/write upper threshold sits at offset 03h and resets to BFFFh.
// - bits 15:12 hold the upper threshold exponent, read/write, reset Bh.
// - bits 11:0 hold the upper threshold mantissa in straight binary, reset FFFh.
// - the reported result value never depends on the mask enable setting.
// - a 16-bit read-only maker code register sits at offset 7Eh.
// - limit lux equals 0.01 times two to the exponent times the mantissa.
// - exponent zero means 40.95 lux full scale at 0.01 lux steps, doubling per step.
module ltl_threshold_regs (
  input  wire logic                i_clk,
  input  wire logic                i_arst_n,
  input  wire logic                i_scl,
  input  wire logic                i_sda,
  output logic                     o_sda_out,
  output logic                     o_sda_oe_n,
  input  wire ltl_pkg::ltl_float_t i_result,
  input  wire logic                i_result_valid,
  input  wire ltl_pkg::ltl_float_t i_lower_limit,
  input  wire logic                i_comparison_mask_enable,
  output ltl_pkg::ltl_float_t      o_result_value,
  output ltl_pkg::ltl_flags_t      o_flags
);

  // ****************************************
  // declarations
  // ****************************************
  ltl_pkg::ltl_state_t         state;
  ltl_pkg::ltl_float_t         upper_limit;
  ltl_pkg::ltl_float_t         cmp_in [3];
  logic [ltl_pkg::LUX_W-1:0]   cmp_lux [3];
  logic                        scl_d;
  logic                        sda_d;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        start_cond;
  logic                        stop_cond;
  logic [3:0]                  bit_cnt;
  logic [7:0]                  rx_shift;
  logic [7:0]                  tx_shift;
  logic [7:0]                  pointer;
  logic [7:0]                  write_msb;
  logic                        byte_hi;
  logic                        read_dir;
  logic [15:0]                 read_word;
  logic [7:0]                  next_tx_byte;
  logic                        byte_done;

  // ****************************************
  // bus edge detection
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= i_scl;
      sda_d <= i_sda;
    end
  end

  assign scl_rise   = i_scl & ~scl_d;
  assign scl_fall   = ~i_scl & scl_d;
  assign start_cond = i_scl & scl_d & sda_d & ~i_sda;
  assign stop_cond  = i_scl & scl_d & ~sda_d & i_sda;
  assign byte_done  = (bit_cnt == ltl_pkg::BITS_PER_BYTE);

  // ****************************************
  // read decode
  // ****************************************
  always_comb begin
    if (pointer == ltl_pkg::REG_UPPER_LUX_THRESHOLD) begin
      read_word = upper_limit;
    end else if (pointer == ltl_pkg::REG_MAKER_IDENTIFICATION) begin
      read_word = ltl_pkg::MAKER_CODE_VALUE;
    end else begin
      read_word = ltl_pkg::UNMAPPED_READ_VALUE;
    end
    next_tx_byte = byte_hi ? read_word[15:8] : read_word[7:0];
  end

  // ****************************************
  // bit sampling
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_shift <= 8'h00;
      bit_cnt  <= 4'h0;
    end else if (start_cond) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise) begin
      rx_shift <= {rx_shift[6:0], i_sda};
      if (state == ltl_pkg::ST_ADDR || state == ltl_pkg::ST_PTR ||
          state == ltl_pkg::ST_WDATA || state == ltl_pkg::ST_RDATA) begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end else if (scl_fall && byte_done) begin
      bit_cnt <= 4'h0;
    end else if (scl_fall && (state == ltl_pkg::ST_ADDR_ACK ||
                 state == ltl_pkg::ST_PTR_ACK || state == ltl_pkg::ST_WDATA_ACK ||
                 state == ltl_pkg::ST_RDATA_ACK)) begin
      bit_cnt <= 4'h0;
    end
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state      <= ltl_pkg::ST_IDLE;
      o_sda_oe_n <= 1'b1;
      tx_shift   <= 8'h00;
      pointer    <= 8'h00;
      write_msb  <= 8'h00;
      byte_hi    <= 1'b1;
      read_dir   <= 1'b0;
    end else if (start_cond) begin
      state      <= ltl_pkg::ST_ADDR;
      o_sda_oe_n <= 1'b1;
    end else if (stop_cond) begin
      state      <= ltl_pkg::ST_IDLE;
      o_sda_oe_n <= 1'b1;
    end else if (scl_fall) begin
      case (state)
        ltl_pkg::ST_ADDR: begin
          if (byte_done) begin
            if (rx_shift[7:1] == ltl_pkg::BUS_DEVICE_ADDRESS) begin
              read_dir   <= rx_shift[0];
              o_sda_oe_n <= 1'b0;
              state      <= ltl_pkg::ST_ADDR_ACK;
            end else begin
              state <= ltl_pkg::ST_IDLE;
            end
          end
        end
        ltl_pkg::ST_ADDR_ACK: begin
          if (read_dir) begin
            // every read begins with the high byte
            tx_shift   <= {read_word[14:8], 1'b0};
            o_sda_oe_n <= read_word[15];
            byte_hi    <= 1'b0;
            state      <= ltl_pkg::ST_RDATA;
          end else begin
            o_sda_oe_n <= 1'b1;
            state      <= ltl_pkg::ST_PTR;
          end
        end
        ltl_pkg::ST_PTR: begin
          if (byte_done) begin
            pointer    <= rx_shift;
            byte_hi    <= 1'b1;
            o_sda_oe_n <= 1'b0;
            state      <= ltl_pkg::ST_PTR_ACK;
          end
        end
        ltl_pkg::ST_PTR_ACK, ltl_pkg::ST_WDATA_ACK: begin
          o_sda_oe_n <= 1'b1;
          state      <= ltl_pkg::ST_WDATA;
        end
        ltl_pkg::ST_WDATA: begin
          if (byte_done) begin
            if (byte_hi) begin
              write_msb <= rx_shift;
            end
            byte_hi    <= ~byte_hi;
            o_sda_oe_n <= 1'b0;
            state      <= ltl_pkg::ST_WDATA_ACK;
          end
        end
        ltl_pkg::ST_RDATA: begin
          if (byte_done) begin
            o_sda_oe_n <= 1'b1;
            state      <= ltl_pkg::ST_RDATA_ACK;
          end else begin
            o_sda_oe_n <= tx_shift[7];
            tx_shift   <= {tx_shift[6:0], 1'b0};
          end
        end
        ltl_pkg::ST_RDATA_ACK: begin
          if (rx_shift[0]) begin
            o_sda_oe_n <= 1'b1;
            state      <= ltl_pkg::ST_IDLE;
          end else begin
            tx_shift   <= {next_tx_byte[6:0], 1'b0};
            o_sda_oe_n <= next_tx_byte[7];
            byte_hi    <= ~byte_hi;
            state      <= ltl_pkg::ST_RDATA;
          end
        end
        default: begin
          o_sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // open drain: the pin only ever pulls low
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sda_out <= 1'b0;
    end else begin
      o_sda_out <= 1'b0;
    end
  end

  // ****************************************
  // upper threshold register
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      upper_limit.exponent <= ltl_pkg::UPPER_EXPONENT_RESET;
      upper_limit.mantissa <= ltl_pkg::UPPER_MANTISSA_RESET;
    end else if (scl_fall && state == ltl_pkg::ST_WDATA && byte_done && !byte_hi &&
                 pointer == ltl_pkg::REG_UPPER_LUX_THRESHOLD) begin
      upper_limit <= {write_msb, rx_shift};
    end
  end

  // ****************************************
  // lux comparison
  // ****************************************
  assign cmp_in[0] = i_result;
  assign cmp_in[1] = upper_limit;
  assign cmp_in[2] = i_lower_limit;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_scale
      ltl_lux_scale u_scale (
        .i_value (cmp_in[gi]),
        .o_lux   (cmp_lux[gi])
      );
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_flags <= '0;
    end else if (i_result_valid) begin
      if (i_comparison_mask_enable) begin
        // exponents assumed equal when masking; mantissas decide
        o_flags.over_threshold_flag  <= i_result.mantissa > upper_limit.mantissa;
        o_flags.under_threshold_flag <= i_result.mantissa < i_lower_limit.mantissa;
      end else begin
        o_flags.over_threshold_flag  <= cmp_lux[0] > cmp_lux[1];
        o_flags.under_threshold_flag <= cmp_lux[0] < cmp_lux[2];
      end
    end
  end

  // ****************************************
  // result value
  // ****************************************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_result_value <= '0;
    end else if (i_result_valid) begin
      o_result_value <= i_result;
    end
  end

endmodule
